// >>> src/scs_smart_card.sv
// smart card clock pin control, transmit engine and status flags
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_smart_card
  import scs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic standby,
  // register port
  input wire scs_bus_type bus,
  output logic [7:0] rd_data,
  // interrupt
  output logic irq,
  // serial clock pin
  output scs_pin_type sck_pin,
  // shared data line
  input wire logic data_in,
  output scs_pin_type data_pin
);
  logic [7:0] mode_reg;
  logic [7:0] rate_reg;
  logic [7:0] serial_control;
  logic [7:0] tdata;
  logic tx_buffer_empty_flag;
  logic error_signal_flag;
  logic transmit_end_flag;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic arm_tx_buffer_empty_flag;
  logic arm_ers;
  logic data_meta;
  logic data_sync;
  logic [15:0] half_cnt;
  logic [15:0] half_limit;
  logic sck_phase;
  logic [7:0] etu_half_cnt;
  logic half_tick;
  logic [4:0] hcnt;
  logic [9:0] frame;
  scs_tx_state_type tx_state;
  logic [7:0] stat_view;
  logic gsm_select;
  logic transmit_enable;
  logic clock_pin_mode_hi;
  logic clock_pin_mode_lo;
  logic wr_stat;
  logic tx_buffer_empty_flag_clear;
  logic ers_clear;
  logic ers_set;
  logic transmit_end_flag_set;
  logic transmit_end_flag_prev;
  logic tx_start;
  logic sck_rise;

  assign gsm_select = mode_reg[`SCS_MODE_GSM]; // [R17]
  assign transmit_enable = serial_control[`SCS_CTRL_TE];
  assign clock_pin_mode_hi = serial_control[`SCS_CTRL_CLOCK_PIN_MODE_HI];
  assign clock_pin_mode_lo = serial_control[`SCS_CTRL_CLOCK_PIN_MODE_LO];
  assign wr_stat = bus.wr && (bus.addr == `SCS_OFF_STAT);
  // flags only clear on a written 0 after a read of 1; a written 1 is ignored
  assign tx_buffer_empty_flag_clear = wr_stat && arm_tx_buffer_empty_flag && !bus.wdata[`SCS_ST_TX_BUFFER_EMPTY_FLAG]; // [R10]
  assign ers_clear = wr_stat && arm_ers && !bus.wdata[`SCS_ST_ERS]; // [R7] [R10]
  // sampled line low at the error point means the card flagged parity
  assign ers_set = (tx_state == scs_send) && half_tick
                   && (hcnt + 5'd1 == `SCS_HALF_ERR_SAMPLE) && !data_sync; // [R6] [R9]
  assign tx_start = (tx_state == scs_idle) && transmit_enable && !tx_buffer_empty_flag
                    && half_tick;
  assign sck_rise = (half_cnt == half_limit) && !sck_phase;

  // status view; receive flags are not produced here and read 0
  always_comb begin
    stat_view = 8'h00;
    stat_view[`SCS_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
    stat_view[`SCS_ST_ERS] = error_signal_flag;
    stat_view[`SCS_ST_TRANSMIT_END_FLAG] = transmit_end_flag;
  end

  // transmit end set conditions, evaluated every cycle
  always_comb begin
    transmit_end_flag_set = !transmit_enable && !error_signal_flag && !ers_set; // [R12]
    if ((tx_state == scs_send) && half_tick && tx_buffer_empty_flag
        && !error_signal_flag && !ers_set) begin
      if (gsm_select && hcnt + 5'd1 == `SCS_HALF_TRANSMIT_END_FLAG_GSM)
        transmit_end_flag_set = 1'b1; // [R14]
      else if (!gsm_select && hcnt + 5'd1 == `SCS_HALF_TRANSMIT_END_FLAG_NORMAL)
        transmit_end_flag_set = 1'b1; // [R13]
    end
  end

  // data line synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_meta <= 1'b1;
      data_sync <= 1'b1;
    end else begin
      data_meta <= data_in;
      data_sync <= data_meta;
    end
  end

  // software registers; control bits 3:2 are dropped on write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= `SCS_RST_MODE;
      rate_reg <= `SCS_RST_RATE;
      serial_control <= `SCS_RST_CTRL;
      tdata <= `SCS_RST_TDATA;
      irq_mask <= 8'h00;
    end else if (standby) begin
      mode_reg <= `SCS_RST_MODE;
      rate_reg <= `SCS_RST_RATE;
      serial_control <= `SCS_RST_CTRL;
      tdata <= `SCS_RST_TDATA;
      irq_mask <= 8'h00;
    end else if (bus.wr) begin
      case (bus.addr)
        `SCS_OFF_MODE: mode_reg <= bus.wdata;
        `SCS_OFF_RATE: rate_reg <= bus.wdata;
        `SCS_OFF_CTRL: serial_control <= bus.wdata & `SCS_CTRL_MASK; // [R5]
        `SCS_OFF_TDATA: tdata <= bus.wdata;
        `SCS_OFF_IRQ_MASK: irq_mask <= bus.wdata;
        default: ;
      endcase
    end
  end

  // read arming of the clear-by-zero flags
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arm_tx_buffer_empty_flag <= 1'b0;
      arm_ers <= 1'b0;
    end else if (standby) begin
      arm_tx_buffer_empty_flag <= 1'b0;
      arm_ers <= 1'b0;
    end else if (bus.rd && bus.addr == `SCS_OFF_STAT) begin
      arm_tx_buffer_empty_flag <= tx_buffer_empty_flag;
      arm_ers <= error_signal_flag;
    end else begin
      if (tx_buffer_empty_flag_clear)
        arm_tx_buffer_empty_flag <= 1'b0;
      if (ers_clear)
        arm_ers <= 1'b0;
    end
  end

  // buffer empty: hardware set on load wins over a software clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      tx_buffer_empty_flag <= 1'b1;
    else if (standby)
      tx_buffer_empty_flag <= 1'b1;
    else if (tx_start)
      tx_buffer_empty_flag <= 1'b1;
    else if (tx_buffer_empty_flag_clear)
      tx_buffer_empty_flag <= 1'b0;
  end

  // error flag; te is not looked at, so clearing te keeps it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      error_signal_flag <= 1'b0; // [R7]
    else if (standby)
      error_signal_flag <= 1'b0; // [R7]
    else if (ers_set)
      error_signal_flag <= 1'b1; // [R6] [R8]
    else if (ers_clear)
      error_signal_flag <= 1'b0; // [R7]
  end

  // transmit end flag; set beats the clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      transmit_end_flag <= 1'b1; // [R15]
    else if (standby)
      transmit_end_flag <= 1'b1; // [R15]
    else if (transmit_end_flag_set)
      transmit_end_flag <= 1'b1; // [R12] [R13] [R14]
    else if (tx_buffer_empty_flag_clear)
      transmit_end_flag <= 1'b0; // [R11]
  end

  // bit clock from the rate register and mode register bits 1:0 only; no outside clock is used
  always_comb begin
    half_limit = 16'(((17'(rate_reg) + 17'd1) << (2 * mode_reg[1:0])) - 17'd1); // [R4]
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      half_cnt <= 16'h0000;
      sck_phase <= 1'b0;
    end else if (standby) begin
      half_cnt <= 16'h0000;
      sck_phase <= 1'b0;
    end else if (half_cnt >= half_limit) begin
      half_cnt <= 16'h0000;
      sck_phase <= !sck_phase; // [R18]
    end else begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end

  // 186 clock periods make half an etu, so 372 make one bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      etu_half_cnt <= 8'h00;
      half_tick <= 1'b0;
    end else if (standby) begin
      etu_half_cnt <= 8'h00;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (sck_rise) begin
        if (etu_half_cnt == `SCS_HALF_ETU_LAST) begin
          etu_half_cnt <= 8'h00;
          half_tick <= 1'b1; // [R16]
        end else begin
          etu_half_cnt <= etu_half_cnt + 8'h01;
        end
      end
    end
  end

  // transmit engine: start, 8 data, parity, then guard and error sampling
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_state <= scs_idle;
      hcnt <= 5'd0;
      frame <= 10'h3ff;
    end else if (standby) begin
      tx_state <= scs_idle;
      hcnt <= 5'd0;
      frame <= 10'h3ff;
    end else begin
      case (tx_state)
        scs_idle: begin
          hcnt <= 5'd0;
          if (tx_start) begin
            frame <= {^tdata ^ mode_reg[`SCS_MODE_ODD], tdata, 1'b0};
            tx_state <= scs_send;
          end
        end
        scs_send: begin
          if (half_tick) begin
            hcnt <= hcnt + 5'd1;
            if (hcnt[0] && hcnt < `SCS_HALF_FRAME_END)
              frame <= {1'b1, frame[9:1]};
            if (ers_set || transmit_end_flag_set || hcnt + 5'd1 == `SCS_HALF_TRANSMIT_END_FLAG_NORMAL)
              tx_state <= scs_guard;
          end
        end
        scs_guard: begin
          // a short pause before the next character may start
          if (half_tick)
            tx_state <= scs_idle;
        end
        default: tx_state <= scs_idle;
      endcase
    end
  end

  // open drain data line: driven only while a zero is sent
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      data_pin <= '{out: 1'b0, oe: 1'b0};
    else
      data_pin <= '{out: 1'b0,
                    oe: (tx_state == scs_send) && (hcnt < `SCS_HALF_FRAME_END) && !frame[0]};
  end

  // clock pin decode; the forbidden gsm-off 1x settings fall back to port
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_pin <= '{out: 1'b0, oe: 1'b0};
    end else if (!gsm_select) begin
      if (!clock_pin_mode_hi && clock_pin_mode_lo)
        sck_pin <= '{out: sck_phase, oe: 1'b1}; // [R1] [R18]
      else
        sck_pin <= '{out: 1'b0, oe: 1'b0}; // [R1] [R2]
    end else if (clock_pin_mode_lo) begin
      sck_pin <= '{out: sck_phase, oe: 1'b1}; // [R3]
    end else begin
      sck_pin <= '{out: clock_pin_mode_hi, oe: 1'b1}; // [R3]
    end
  end

  // interrupt sources: error flag set and transmit end rising
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status <= 8'h00;
      transmit_end_flag_prev <= 1'b1;
    end else if (standby) begin
      irq_status <= 8'h00;
      transmit_end_flag_prev <= 1'b1;
    end else begin
      transmit_end_flag_prev <= transmit_end_flag;
      for (int i = 0; i < 8; i++) begin
        if ((i == `SCS_IRQ_ERS && ers_set)
            || (i == `SCS_IRQ_TRANSMIT_END_FLAG && transmit_end_flag && !transmit_end_flag_prev))
          irq_status[i] <= 1'b1;
        else if (bus.wr && bus.addr == `SCS_OFF_IRQ_STAT && bus.wdata[i])
          irq_status[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `SCS_OFF_MODE: rd_data <= mode_reg;
        `SCS_OFF_RATE: rd_data <= rate_reg;
        `SCS_OFF_CTRL: rd_data <= serial_control;
        `SCS_OFF_TDATA: rd_data <= tdata;
        `SCS_OFF_STAT: rd_data <= stat_view;
        `SCS_OFF_IRQ_STAT: rd_data <= irq_status;
        `SCS_OFF_IRQ_MASK: rd_data <= irq_mask;
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_port_pin;
    (!gsm_select && serial_control[1:0] == 2'b00) |=> !sck_pin.oe;
  endproperty
  a_port_pin: assert property (p_port_pin) else $error("port mode drives clock pin"); // [R1]

  property p_clock_out;
    (!gsm_select && serial_control[1:0] == 2'b01) |=> (sck_pin.oe && sck_pin.out == $past(sck_phase));
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock not on pin"); // [R1]

  property p_fixed_level;
    (gsm_select && !clock_pin_mode_lo)
      |=> (sck_pin.oe && sck_pin.out == $past(clock_pin_mode_hi));
  endproperty
  a_fixed_level: assert property (p_fixed_level) else $error("fixed level wrong"); // [R3]

  property p_half_period;
    (half_cnt >= half_limit && !standby) |=> (sck_phase != $past(sck_phase));
  endproperty
  a_half_period: assert property (p_half_period) else $error("clock phase stuck"); // [R18]

  property p_error_detect;
    (ers_set && !standby) |=> (error_signal_flag && irq_status[`SCS_IRQ_ERS]);
  endproperty
  a_error_detect: assert property (p_error_detect) else $error("error level missed"); // [R6]

  property p_error_kept;
    (error_signal_flag && !ers_clear && !standby) |=> error_signal_flag;
  endproperty
  a_error_kept: assert property (p_error_kept) else $error("error flag lost"); // [R8]

  property p_write_one;
    (wr_stat && bus.wdata[`SCS_ST_ERS] && !ers_set && !standby)
      |=> (error_signal_flag == $past(error_signal_flag));
  endproperty
  a_write_one: assert property (p_write_one) else $error("written one changed flag"); // [R10]

  property p_idle_end;
    (!transmit_enable && !error_signal_flag && !ers_set) |=> transmit_end_flag;
  endproperty
  a_idle_end: assert property (p_idle_end) else $error("idle end flag low"); // [R12]

  property p_end_clear;
    (tx_buffer_empty_flag_clear && !transmit_end_flag_set && !standby) |=> (!transmit_end_flag && !tx_buffer_empty_flag);
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("end flag not cleared"); // [R11]

  property p_gsm_end;
    (gsm_select && tx_state == scs_send && half_tick && hcnt + 5'd1 == `SCS_HALF_TRANSMIT_END_FLAG_GSM
     && tx_buffer_empty_flag && !error_signal_flag && !ers_set && !standby)
      |=> transmit_end_flag;
  endproperty
  a_gsm_end: assert property (p_gsm_end) else $error("gsm end timing wrong"); // [R14]

  property p_standby;
    standby |=> (transmit_end_flag && !error_signal_flag);
  endproperty
  a_standby: assert property (p_standby) else $error("standby flags wrong"); // [R15]
endmodule : scs_smart_card

// >>> src/scs_defs.svh
// constants of the smart card clock and status block
// Overview of operation
// R1: gsm off: mode 00 leaves clock pin to port, 01 drives bit clock.
// R2: software never sets clock mode high bit while gsm select is off.
// R3: gsm on: 00 holds pin low, 10 holds high, low bit set outputs clock.
// R4: transfer clock always comes from the internal generator, never from outside.
// R5: control bits 3 and 2 have no effect on the port.
// R6: card driving error level low during transmit sets status bit 4.
// R7: error flag clears by writing 0 after reading 1, or by reset/standby.
// R8: turning transmit enable off leaves the error flag unchanged.
// R9: no framing error check; status bit 4 only reports the error signal.
// R10: status bits 7 to 3 take only a written 0, which clears; 1 ignored.
// R11: transmit end clears when buffer-empty flag is written 0 after reading 1.
// R12: transmit end sets while transmit enable and error flag are both 0.
// R13: gsm off: transmit end sets 2.5 etu after a clean character.
// R14: gsm on: transmit end sets 1.0 etu after a clean character.
// R15: transmit end reads 1 when done; reset and standby set it to 1.
// R16: etu delays count bit times at the programmed rate.
// R17: gsm select lives in mode register bit 7.
// R18: output clock runs at 372 times the bit rate.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_ADDR_W 6
`define SCS_OFF_MODE 6'h00
`define SCS_OFF_RATE 6'h04
`define SCS_OFF_CTRL 6'h08
`define SCS_OFF_TDATA 6'h0c
`define SCS_OFF_STAT 6'h10
`define SCS_OFF_IRQ_STAT 6'h20
`define SCS_OFF_IRQ_MASK 6'h24
`define SCS_RST_MODE 8'h00
`define SCS_RST_RATE 8'hff
`define SCS_RST_CTRL 8'h00
`define SCS_RST_TDATA 8'hff
`define SCS_MODE_GSM 7
`define SCS_MODE_ODD 4
`define SCS_CTRL_TE 5
`define SCS_CTRL_CLOCK_PIN_MODE_HI 1
`define SCS_CTRL_CLOCK_PIN_MODE_LO 0
`define SCS_CTRL_MASK 8'hf3
`define SCS_ST_TX_BUFFER_EMPTY_FLAG 7
`define SCS_ST_ERS 4
`define SCS_ST_TRANSMIT_END_FLAG 2
`define SCS_IRQ_ERS 0
`define SCS_IRQ_TRANSMIT_END_FLAG 1
`define SCS_ETU_SCK 9'd372
`define SCS_HALF_ETU_LAST 8'd185
`define SCS_HALF_FRAME_END 5'd20
// elapsed half etus from the start edge; the tick that ends half etu n sees hcnt at n - 1
`define SCS_HALF_ERR_SAMPLE 5'd22
`define SCS_HALF_TRANSMIT_END_FLAG_NORMAL 5'd25
`define SCS_HALF_TRANSMIT_END_FLAG_GSM 5'd22
`endif

// >>> src/scs_pkg.sv
// types of the smart card clock and status block
`include "scs_defs.svh"
package scs_pkg;
  typedef enum logic [1:0] {scs_idle, scs_send, scs_guard} scs_tx_state_type;
  typedef struct packed {
    logic out;
    logic oe;
  } scs_pin_type;
  typedef struct packed {
    logic [`SCS_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_type;
endpackage : scs_pkg

// >>> sim/scs_card_model.sv
// card model on the shared open-drain data line
`timescale 1ns/1ps
module scs_card_model
  import scs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // line from the block and error request
  input wire scs_pin_type data_pin,
  input wire logic err_en,
  // resolved line level
  output logic line
);
  localparam int ETU = 744;
  int cnt;
  logic busy;
  logic pull_low;
  // pull-up wins only while nobody drives low
  assign line = ((data_pin.oe && !data_pin.out) || pull_low) ? 1'b0 : 1'b1;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 0;
      pull_low <= 1'b0;
    end else if (!busy) begin
      if (data_pin.oe && !data_pin.out) begin
        busy <= 1'b1;
        cnt <= 1;
      end
    end else begin
      cnt <= cnt + 1;
      // error signal low from 10.5 to 11.5 etu after the start edge
      pull_low <= err_en && cnt >= ETU * 21 / 2 && cnt < ETU * 23 / 2;
      if (cnt >= ETU * 12) begin
        busy <= 1'b0;
      end
    end
  end
endmodule : scs_card_model

// >>> sim/scs_smart_card_bench.sv
// testbench of the smart card clock and status block
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_smart_card_bench
  import scs_pkg::*;
;
  localparam int H = 372;
  logic clock, resetn, standby, err_en, irq, line;
  scs_bus_type bus;
  logic [7:0] rd_data, d;
  scs_pin_type sck_pin, data_pin;
  int n_mismatch, checked;
  scs_smart_card dut (.clock(clock), .resetn(resetn), .standby(standby), .bus(bus),
    .rd_data(rd_data), .irq(irq), .sck_pin(sck_pin), .data_in(line), .data_pin(data_pin));
  scs_card_model card (.clock(clock), .resetn(resetn), .data_pin(data_pin),
    .err_en(err_en), .line(line));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task chk8(string s, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : chk8
  task chk1(string s, logic e, logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", s, e, g);
    end
  endtask : chk1
  task cyc(int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task wr(logic [`SCS_ADDR_W-1:0] a, logic [7:0] v);
    @(posedge clock);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '{a, v, 1'b0, 1'b0};
  endtask : wr
  // read data stands only in the cycle after the strobe
  task rd(logic [`SCS_ADDR_W-1:0] a);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rd_data;
  endtask : rd
  task rdc(string s, logic [`SCS_ADDR_W-1:0] a, logic [7:0] e);
    rd(a);
    chk8(s, e, d);
  endtask : rdc
  task t_reset;
    rdc("status", `SCS_OFF_STAT, 8'h84);
    rdc("mode", `SCS_OFF_MODE, 8'h00);
    rdc("rate", `SCS_OFF_RATE, 8'hff);
    rdc("ctrl", `SCS_OFF_CTRL, 8'h00);
    rdc("tdata", `SCS_OFF_TDATA, 8'hff);
    rdc("unmapped", 6'h3c, 8'h00);
    chk1("irq", 1'b0, irq);
    wr(`SCS_OFF_CTRL, 8'h0c);
    rdc("ctrl", `SCS_OFF_CTRL, 8'h00);
    cyc(3);
    chk1("sck oe", 1'b0, sck_pin.oe);
  endtask : t_reset
  // entries gsm, mode hi, mode lo, oe, level; gsm off with mode hi set is never used
  task t_sck;
    logic [4:0] tab [6];
    logic p;
    logic [7:0] n;
    tab = '{5'b00000, 5'b00110, 5'b10010, 5'b11011, 5'b10110, 5'b11110};
    wr(`SCS_OFF_RATE, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(`SCS_OFF_MODE, {tab[i][4], 7'h00});
      wr(`SCS_OFF_CTRL, {6'h00, tab[i][3:2]});
      cyc(4);
      chk1("sck oe", tab[i][1], sck_pin.oe);
      n = 8'h00;
      p = sck_pin.out;
      if (tab[i][2]) begin
        repeat (H) begin
          @(posedge clock);
          #1 if (sck_pin.out && !p) n++;
          p = sck_pin.out;
        end
        chk8("sck periods per half etu", 8'd186, n);
      end else if (tab[i][1]) begin
        chk1("sck level", tab[i][0], sck_pin.out);
      end
    end
    // rate 1 doubles the half period, so half the clock edges
    wr(`SCS_OFF_RATE, 8'h01);
    cyc(4);
    n = 8'h00;
    p = sck_pin.out;
    repeat (H) begin
      @(posedge clock);
      #1 if (sck_pin.out && !p) n++;
      p = sck_pin.out;
    end
    chk8("sck periods at rate 1", 8'd93, n);
    wr(`SCS_OFF_RATE, 8'h00);
    wr(`SCS_OFF_CTRL, 8'h00);
  endtask : t_sck
  task t_tx(logic gsm, logic odd, logic [7:0] v, logic err);
    logic [9:0] f;
    int t;
    f = {^v ^ odd, v, 1'b0};
    t = gsm ? 22 : 25;
    err_en <= err;
    wr(`SCS_OFF_MODE, {gsm, 2'b00, odd, 4'h0});
    wr(`SCS_OFF_CTRL, 8'h20);
    wr(`SCS_OFF_TDATA, v);
    rd(`SCS_OFF_STAT);
    wr(`SCS_OFF_STAT, 8'h00);
    rd(`SCS_OFF_STAT);
    chk1("transmit_end_flag after buffer write", 1'b0, d[2]);
    for (int i = 0; i < 2000 && line !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    cyc(H);
    for (int k = 0; k < 10; k++) begin
      chk1("line bit", f[k], line);
      if (k < 9) cyc(2 * H);
    end
    // look a quarter etu before and after the expected transmit end
    cyc((t - 19) * H - H / 2 - 2);
    rd(`SCS_OFF_STAT);
    chk1("transmit_end_flag early", 1'b0, d[2]);
    cyc(H);
    rdc("status after frame", `SCS_OFF_STAT, err ? 8'h90 : 8'h84);
    err_en <= 1'b0;
  endtask : t_tx
  // error flag survives transmit off and ones, clears on read then zero
  task t_err_clear;
    wr(`SCS_OFF_CTRL, 8'h00);
    rdc("status te off", `SCS_OFF_STAT, 8'h90);
    wr(`SCS_OFF_STAT, 8'hff);
    rdc("status ones", `SCS_OFF_STAT, 8'h90);
    wr(`SCS_OFF_STAT, 8'hef);
    rdc("status cleared", `SCS_OFF_STAT, 8'h84);
    rdc("irq status transmit_end_flag rise", `SCS_OFF_IRQ_STAT, 8'h02);
  endtask : t_err_clear
  task t_standby;
    wr(`SCS_OFF_MODE, 8'h80);
    wr(`SCS_OFF_CTRL, 8'h01);
    rd(`SCS_OFF_STAT);
    wr(`SCS_OFF_STAT, 8'h00);
    rdc("status before standby", `SCS_OFF_STAT, 8'h04);
    @(posedge clock);
    standby <= 1'b1;
    cyc(2);
    standby <= 1'b0;
    rdc("status", `SCS_OFF_STAT, 8'h84);
    rdc("mode", `SCS_OFF_MODE, 8'h00);
    rdc("ctrl", `SCS_OFF_CTRL, 8'h00);
  endtask : t_standby
  task results;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  initial begin
    resetn = 1'b0;
    standby = 1'b0;
    err_en = 1'b0;
    bus = '0;
    n_mismatch = 0;
    checked = 0;
    cyc(3);
    resetn <= 1'b1;
    t_reset;
    t_sck;
    wr(`SCS_OFF_IRQ_MASK, 8'h00);
    t_tx(1'b0, 1'b0, 8'h3b, 1'b0);
    chk1("irq masked", 1'b0, irq);
    t_tx(1'b1, 1'b0, 8'ha5, 1'b0);
    t_tx(1'b0, 1'b1, 8'h3f, 1'b0);
    wr(`SCS_OFF_IRQ_STAT, 8'h03);
    wr(`SCS_OFF_IRQ_MASK, 8'h01);
    t_tx(1'b0, 1'b0, 8'h5c, 1'b1);
    cyc(2);
    chk1("irq raised", 1'b1, irq);
    wr(`SCS_OFF_IRQ_STAT, 8'h01);
    cyc(2);
    chk1("irq cleared", 1'b0, irq);
    t_err_clear;
    t_standby;
    results;
  end
  // the whole run needs about 40000 cycles
  initial begin
    cyc(90000);
    n_mismatch++;
    results;
  end
endmodule : scs_smart_card_bench
